// ### hdl/spt_programmer.sv
// Supply-pulse threshold programmer with classic Wishbone registers
// What this block does
// - Operate threshold code is five bits, 31 steps, one bitfield each.
// - Release threshold follows operate threshold by a fixed hysteresis.
// - Each mid pulse in addressing advances the address counter until it saturates at ADDR_MAX.
// - Short high pulse separates groups; long high pulse blows addressed fuse.
// - Supply near zero clears provisional bits and address state.
// - Three levels: hold, count, high; zero clears.
// - Provisional and permanent sequences match except the fuse pulse.
// - Sequence order: enable key, address group, optional fuse pulse.
// - A blown bitfield fuse reads as one forever.
// - Unset bitfields read zero; zero bitfields are never fused.
// - Provisional try uses address count equal to decimal value.
// - Permanent coding writes each one-bit by its own address.
// - Addressing opens after short high, mid, short high, unbroken.
// - Address equals count of mid pulses after the key.
// - Lock bit at address 32; once blown all coding is refused.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module spt_programmer import spt_pkg::*; #(
  parameter int SEQ_CYC = SEQ_PULSE_CYC,
  parameter int LONG_CYC = LONG_SPLIT_CYC,
  parameter int IDLE_TMO_CYC = IDLE_CYC,
  parameter logic [4:0] HYST_STEPS = HYST_STEPS_RST
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Supply comparators
  input wire logic SUP_PRESENT_IN,
  input wire logic SUP_MID_IN,
  input wire logic SUP_HIGH_IN,
  // Fuse array
  input wire logic [4:0] FUSE_BITS_IN,
  input wire logic FUSE_LOCK_IN,
  output logic FUSE_BLOW_OUT,
  output logic [5:0] FUSE_SEL_OUT,
  // Thresholds and lock state
  output logic [4:0] OPERATE_CODE_OUT,
  output logic [4:0] RELEASE_CODE_OUT,
  output logic LOCKED_OUT,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  spt_state_t state_r, state_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [4:0] prov_r;
  logic prov_lock_r;
  logic [5:0] fs0_r, fs1_r, fs2_r, fuse_r;
  logic [19:0] idle_r;
  logic en_r;
  logic clr_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic blow_r;
  logic [5:0] sel_r;
  logic [4:0] code_r;
  logic [4:0] rel_r;
  logic present, high_lvl;
  logic ev_mid, ev_short, ev_long, ev_end;
  logic commit, wipe, idle_hit;
  logic supply_lost;
  logic addr_bit_ok, addr_lock, addr_prov_ok;

  // ----------------------------------------
  // Pulse classifier
  // ----------------------------------------
  spt_pulse_class #(
    .SEQ_CYC(SEQ_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_class (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .lvl_in({SUP_HIGH_IN, SUP_MID_IN, SUP_PRESENT_IN}),
    .present_out(present),
    .high_out(high_lvl),
    .ev_mid_out(ev_mid),
    .ev_short_out(ev_short),
    .ev_long_out(ev_long),
    .ev_end_out(ev_end)
  );

  // ----------------------------------------
  // Fuse state sync
  // ----------------------------------------
  // Fuse sense lines are static, so a vector sync is safe here
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fs0_r <= 6'h00;
      fs1_r <= 6'h00;
      fs2_r <= 6'h00;
      fuse_r <= 6'h00;
    end else begin
      fs0_r <= {FUSE_LOCK_IN, FUSE_BITS_IN};
      fs1_r <= fs0_r;
      fs2_r <= fs1_r;
      if (fs1_r == fs2_r) begin
        fuse_r <= fs2_r;
      end
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Fusing: address n selects code bit n-1
  assign addr_bit_ok = (addr_r != 6'h00) && (addr_r <= 6'(CODE_W));
  assign addr_lock = (addr_r == LOCK_ADDR);
  // Provisional try: count is the code value itself
  assign addr_prov_ok = (addr_r != 6'h00) && (addr_r < LOCK_ADDR);
  assign idle_hit = (idle_r == 20'(IDLE_TMO_CYC - 1));
  // Supply loss and disable always win; a software clear can lose to a commit
  assign supply_lost = !present || !en_r;
  // Zero supply or a software clear wipes the sequence, address and fuse drive state
  assign wipe = supply_lost || clr_r;
  // Group closes at the next separator or after a quiet spell
  assign commit = (state_r == ST_ADDR) && (ev_short || idle_hit);

  // ----------------------------------------
  // Sequence state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    unique case (state_r)
      ST_IDLE: begin
        if (ev_short) begin
          state_nxt = ST_KEY1;
        end
      end
      ST_KEY1: begin
        // A long pulse inside the key is a broken key, not a fuse request
        if (ev_mid) begin
          state_nxt = ST_KEY2;
        end else if (ev_long) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_KEY2: begin
        if (ev_short) begin
          state_nxt = ST_ADDR;
          addr_nxt = 6'h00;
        end else if (ev_mid || ev_long) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ADDR: begin
        if (ev_mid) begin
          if (addr_r != ADDR_MAX) begin
            addr_nxt = addr_r + 6'h01;
          end
        end else if (ev_short) begin
          // The separator doubles as the first key pulse of the next one
          state_nxt = ST_KEY1;
        end else if (ev_long) begin
          state_nxt = (addr_bit_ok || addr_lock) ? ST_FUSE : ST_DONE;
        end else if (idle_hit) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FUSE: begin
        if (ev_end || !high_lvl) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Supply loss, a disable or a software clear must come before the next permanent sequence
        state_nxt = ST_DONE;
      end
      // Two codes of the state word are unused; an upset falls back to idle
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_r <= ST_IDLE;
      addr_r <= 6'h00;
    end else if (wipe || fuse_r[5]) begin
      state_r <= ST_IDLE;
      addr_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------
  // Idle timer for the address group
  // ----------------------------------------
  // Without it a lone provisional try would never commit
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      idle_r <= 20'h0;
    end else if (state_r != ST_ADDR || ev_mid || ev_short || ev_long) begin
      idle_r <= 20'h0;
    end else if (!idle_hit) begin
      idle_r <= idle_r + 20'h1;
    end
  end

  // ----------------------------------------
  // Provisional bitfields
  // ----------------------------------------
  // Earlier sequences are kept until supply loss, a disable or a software clear
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prov_r <= 5'h00;
      prov_lock_r <= 1'b0;
    end else if (supply_lost) begin
      prov_r <= 5'h00;
      prov_lock_r <= 1'b0;
    end else if (commit && !fuse_r[5]) begin
      // A commit beats a software clear in the same cycle
      if (addr_prov_ok) begin
        prov_r <= (clr_r ? 5'h00 : prov_r) | addr_r[4:0];
      end else if (clr_r) begin
        prov_r <= 5'h00;
      end
      if (addr_lock) begin
        prov_lock_r <= 1'b1;
      end else if (clr_r) begin
        prov_lock_r <= 1'b0;
      end
    end else if (clr_r) begin
      prov_r <= 5'h00;
      prov_lock_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fuse drive
  // ----------------------------------------
  // Held from the long split to the end of the pulse; the pulse supplies the blow energy
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      blow_r <= 1'b0;
      sel_r <= 6'h00;
    end else if (wipe || fuse_r[5]) begin
      blow_r <= 1'b0;
      sel_r <= 6'h00;
    end else if (state_r == ST_ADDR && ev_long && (addr_bit_ok || addr_lock)) begin
      blow_r <= 1'b1;
      sel_r <= addr_r;
    end else if (state_r == ST_FUSE && (ev_end || !high_lvl)) begin
      blow_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Threshold codes
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      code_r <= 5'h00;
      rel_r <= 5'h00;
    end else begin
      // Unset bits read zero; blown fuses always read one
      code_r <= prov_r | fuse_r[4:0];
      // Release point has no bits of its own
      rel_r <= (code_r > HYST_STEPS) ? code_r - HYST_STEPS : 5'h00;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= WB_CYC_IN && WB_STB_IN && !ack_r;
    end
  end

  // Writes land on the edge where the master sees ack
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      en_r <= CTRL_EN_RST;
      clr_r <= 1'b0;
    end else begin
      clr_r <= 1'b0;
      if (ack_r && WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_SEL_IN[0]
          && WB_ADR_IN == REG_CTRL) begin
        en_r <= WB_DAT_IN[CTRL_EN_BIT];
        clr_r <= WB_DAT_IN[CTRL_CLR_BIT];
      end
    end
  end

  // Unmapped offsets answer with zero
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dat_r <= 32'h0;
    end else if (WB_CYC_IN && WB_STB_IN && !ack_r) begin
      unique case (WB_ADR_IN)
        REG_STATUS: begin
          dat_r <= {12'h000, present, blow_r, prov_lock_r, fuse_r[5],
                    2'b00, addr_r, 5'h00, 3'(state_r)};
        end
        REG_CODE: begin
          dat_r <= {11'h000, fuse_r[4:0], 3'h0, prov_r, 3'h0, code_r};
        end
        REG_CTRL: begin
          dat_r <= {31'h0, en_r};
        end
        default: begin
          dat_r <= 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = dat_r;
  assign FUSE_BLOW_OUT = blow_r;
  assign FUSE_SEL_OUT = sel_r;
  assign OPERATE_CODE_OUT = code_r;
  assign RELEASE_CODE_OUT = rel_r;
  assign LOCKED_OUT = fuse_r[5];

endmodule : spt_programmer

// ### hdl/spt_pulse_class.sv
// Supply level synchroniser and pulse classifier
`timescale 1ns/1ns
module spt_pulse_class import spt_pkg::*; #(
  parameter int SEQ_CYC = SEQ_PULSE_CYC,
  parameter int LONG_CYC = LONG_SPLIT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Level comparator pins: present, mid, high
  input wire logic [2:0] lvl_in,
  // Synchronised levels and classified events
  output logic present_out,
  output logic high_out,
  output logic ev_mid_out,
  output logic ev_short_out,
  output logic ev_long_out,
  output logic ev_end_out
);

  // ----------------------------------------
  // Three-stage sync, change taken once stages agree
  // ----------------------------------------
  logic [2:0] s0_r, s1_r, s2_r, lvl_r;
  logic [19:0] cnt_r;
  logic saw_high_r, long_r, mid_d_r;

  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        s0_r[g] <= 1'b0;
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        lvl_r[g] <= 1'b0;
      end else begin
        s0_r[g] <= lvl_in[g];
        s1_r[g] <= s0_r[g];
        s2_r[g] <= s1_r[g];
        if (s1_r[g] == s2_r[g]) begin
          lvl_r[g] <= s2_r[g];
        end
      end
    end
  end

  // Mid comparator also trips at high level; hold level is present only
  wire logic mid_lvl = lvl_r[1] | lvl_r[2];
  assign present_out = lvl_r[0];
  assign high_out = lvl_r[2];

  // ----------------------------------------
  // Width measurement
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 20'h0;
      saw_high_r <= 1'b0;
      long_r <= 1'b0;
      mid_d_r <= 1'b0;
      ev_mid_out <= 1'b0;
      ev_short_out <= 1'b0;
      ev_long_out <= 1'b0;
      ev_end_out <= 1'b0;
    end else begin
      mid_d_r <= mid_lvl;
      ev_mid_out <= 1'b0;
      ev_short_out <= 1'b0;
      ev_long_out <= 1'b0;
      ev_end_out <= 1'b0;
      if (mid_lvl && !mid_d_r) begin
        cnt_r <= 20'h0;
        saw_high_r <= lvl_r[2];
        long_r <= 1'b0;
      end else if (mid_lvl) begin
        if (cnt_r != 20'hfffff) begin
          cnt_r <= cnt_r + 20'h1;
        end
        if (lvl_r[2]) begin
          saw_high_r <= 1'b1;
        end
        // Long is flagged at the split, so a fuse can blow mid-pulse
        if (saw_high_r && !long_r && cnt_r == 20'(LONG_CYC - 1)) begin
          long_r <= 1'b1;
          ev_long_out <= 1'b1;
        end
      end else if (mid_d_r) begin
        // Narrow glitches are dropped as supply noise
        if (cnt_r >= 20'(SEQ_CYC - 1)) begin
          ev_mid_out <= !saw_high_r;
          ev_short_out <= saw_high_r && !long_r;
        end
        ev_end_out <= saw_high_r;
      end
    end
  end

endmodule : spt_pulse_class

// ### pkg/spt_pkg.sv
// Constants and types for the supply-pulse threshold programmer
package spt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  // Least width of a counted pulse (sequence_pulse_width)
  localparam int T_SEQ_PULSE_NS = 20000;
  // Short/long split, between sequence and fuse_pulse_width minimums
  localparam int T_LONG_SPLIT_NS = 60000;
  // Quiet time that closes a provisional address group
  localparam int T_IDLE_NS = 1000000;
  localparam int SEQ_PULSE_CYC = (T_SEQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_SPLIT_CYC = (T_LONG_SPLIT_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC = (T_IDLE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Code layout
  // ----------------------------------------
  localparam int CODE_W = 5;
  localparam int ADDR_W = 6;
  localparam logic [5:0] LOCK_ADDR = 6'h20;
  localparam logic [5:0] ADDR_MAX = 6'h3f;
  localparam logic [4:0] HYST_STEPS_RST = 5'h01;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CODE = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_ADDR_LSB = 8;
  localparam int STAT_LOCK_BIT = 16;
  localparam int STAT_PLOCK_BIT = 17;
  localparam int STAT_BLOW_BIT = 18;
  localparam int STAT_SUP_BIT = 19;
  localparam int CODE_PROV_LSB = 8;
  localparam int CODE_FUSE_LSB = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_KEY1, ST_KEY2, ST_ADDR, ST_FUSE, ST_DONE
  } spt_state_t;

endpackage : spt_pkg

// ### verif/spt_prog_model.sv
// Programmer pulse source and fuse array model for the supply pins
`timescale 1ns/1ns
module spt_prog_model (
  // Clock and fuse drive
  input wire logic clk_in,
  input wire logic blow_in,
  input wire logic [5:0] sel_in,
  // Supply comparators and fuses
  output logic present_out,
  output logic mid_out,
  output logic high_out,
  output logic [4:0] fuse_out,
  output logic lock_out
);
  initial begin
    present_out = 1'b0;
    mid_out = 1'b0;
    high_out = 1'b0;
    fuse_out = 5'h00;
    lock_out = 1'b0;
  end
  // Blown fuses never heal
  always @(posedge clk_in) begin
    if (blow_in && sel_in >= 6'h01 && sel_in <= 6'h05) begin
      fuse_out <= fuse_out | (5'h01 << (sel_in - 6'h01));
    end
    if (blow_in && sel_in == 6'h20) begin
      lock_out <= 1'b1;
    end
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold
  // High pulses also pass the mid comparator
  task automatic pulse(input logic hi, input int w);
    mid_out <= 1'b1;
    high_out <= hi;
    hold(w);
    mid_out <= 1'b0;
    high_out <= 1'b0;
    hold(12);
  endtask : pulse
  task automatic supply(input logic on);
    present_out <= on;
    hold(12);
  endtask : supply
  // Key may reuse a separator already sent
  task automatic seq(input int n, input logic fz, input logic first);
    if (first) pulse(1'b1, 10);
    pulse(1'b0, 10);
    pulse(1'b1, 10);
    repeat (n) pulse(1'b0, 10);
    if (fz) pulse(1'b1, 75);
  endtask : seq
endmodule : spt_prog_model

// ### verif/spt_programmer_chk.sv
// Assertions on the programmer's top-level ports
`timescale 1ns/1ns
module spt_programmer_chk #(
  parameter int LONG_CYC = 20,
  parameter logic [4:0] HYST_STEPS = 5'h01
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SUP_PRESENT_IN,
  input wire logic SUP_HIGH_IN,
  input wire logic [4:0] FUSE_BITS_IN,
  input wire logic FUSE_BLOW_OUT,
  input wire logic [5:0] FUSE_SEL_OUT,
  input wire logic [4:0] OPERATE_CODE_OUT,
  input wire logic [4:0] RELEASE_CODE_OUT,
  input wire logic LOCKED_OUT,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_blow_long: assert property ($rose(FUSE_BLOW_OUT) |-> $past(SUP_HIGH_IN, LONG_CYC))
    else $error("fuse drive before a long high pulse");
  a_blow_sel_legal: assert property (FUSE_BLOW_OUT |-> FUSE_SEL_OUT inside {[6'h01:6'h05], 6'h20})
    else $error("fuse drive at illegal address");
  a_lock_blocks: assert property (LOCKED_OUT |-> !$rose(FUSE_BLOW_OUT))
    else $error("fuse drive while locked");
  a_release_hyst: assert property (RELEASE_CODE_OUT == (($past(OPERATE_CODE_OUT) >= HYST_STEPS)
    ? $past(OPERATE_CODE_OUT) - HYST_STEPS : 5'h00))
    else $error("release code off operate code");
  a_fuse_sticky: assert property ($stable(FUSE_BITS_IN) [*6]
    |-> (OPERATE_CODE_OUT & FUSE_BITS_IN) == FUSE_BITS_IN)
    else $error("blown bit not seen in code");
  a_zero_clears: assert property ((!SUP_PRESENT_IN && $stable(FUSE_BITS_IN)) [*8]
    |-> OPERATE_CODE_OUT == FUSE_BITS_IN && !FUSE_BLOW_OUT)
    else $error("supply loss left provisional state");
  a_blow_ends: assert property ($fell(SUP_HIGH_IN) |-> ##[0:6] !FUSE_BLOW_OUT)
    else $error("fuse drive outlived high pulse");
  a_ack_next: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT)
    |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("bus answer not one cycle");
  c_lock_blow: cover property (FUSE_BLOW_OUT && FUSE_SEL_OUT == 6'h20);
  c_code_five: cover property (OPERATE_CODE_OUT == 5'h05);
  c_locked: cover property ($rose(LOCKED_OUT));
endmodule : spt_programmer_chk

bind spt_programmer spt_programmer_chk #(.LONG_CYC(LONG_CYC), .HYST_STEPS(HYST_STEPS)) u_chk (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SUP_PRESENT_IN(SUP_PRESENT_IN),
  .SUP_HIGH_IN(SUP_HIGH_IN), .FUSE_BITS_IN(FUSE_BITS_IN), .FUSE_BLOW_OUT(FUSE_BLOW_OUT),
  .FUSE_SEL_OUT(FUSE_SEL_OUT), .OPERATE_CODE_OUT(OPERATE_CODE_OUT),
  .RELEASE_CODE_OUT(RELEASE_CODE_OUT), .LOCKED_OUT(LOCKED_OUT),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT));

// ### verif/test_spt_programmer.sv
// Self-checking bench for the supply-pulse threshold programmer
`timescale 1ns/1ns
module test_spt_programmer import spt_pkg::*;;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic [3:0] bsel = 4'hf;
  logic sel0 = 1'b1;
  logic ack, blow, pres, mid, high, flock, locked;
  logic [5:0] sel;
  logic [4:0] fuse, op, rel;
  int n_errors = 0;
  int check_count = 0;
  int prov = 0;
  int fz = 0;
  int n;
  always #2 clk_in = ~clk_in;
  spt_prog_model pm (.clk_in(clk_in), .blow_in(blow), .sel_in(sel), .present_out(pres),
    .mid_out(mid), .high_out(high), .fuse_out(fuse), .lock_out(flock));
  spt_programmer #(.SEQ_CYC(4), .LONG_CYC(20), .IDLE_TMO_CYC(200)) uut (
    .CLK_IN(clk_in), .SYS_RST_IN(rst_in), .SUP_PRESENT_IN(pres), .SUP_MID_IN(mid),
    .SUP_HIGH_IN(high), .FUSE_BITS_IN(fuse), .FUSE_LOCK_IN(flock), .FUSE_BLOW_OUT(blow),
    .FUSE_SEL_OUT(sel), .OPERATE_CODE_OUT(op), .RELEASE_CODE_OUT(rel), .LOCKED_OUT(locked),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(bsel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    bsel <= {3'($urandom), sel0};
    // Ack and read data are taken as sampled at the same rising edge
    do begin
      @(posedge clk_in);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb
  // Released code trails operate code by one cycle
  task automatic codes;
    pm.hold(8);
    check("operate", {27'h0, op}, prov | fz);
    check("release", {27'h0, rel}, ((prov | fz) > int'(HYST_STEPS_RST)) ?
      (prov | fz) - int'(HYST_STEPS_RST) : 0);
  endtask : codes
  task automatic cycle_power;
    pm.supply(1'b0);
    pm.supply(1'b1);
  endtask : cycle_power
  initial begin
    void'($urandom(70490));
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", q, {31'h0, CTRL_EN_RST});
    // A control write without its low byte lane selected is dropped
    sel0 = 1'b0;
    wb(1'b1, REG_CTRL, 32'h0);
    sel0 = 1'b1;
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl lane", q, {31'h0, CTRL_EN_RST});
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    check("unmapped", q, 32'h0);
    codes();
    $display("reset test done");
    pm.supply(1'b1);
    pm.seq(5, 1'b0, 1'b1);
    pm.pulse(1'b1, 10);
    prov = 5;
    codes();
    n = $urandom_range(31, 1);
    pm.seq(n, 1'b0, 1'b0);
    pm.hold(260);
    prov = prov | n;
    codes();
    wb(1'b0, REG_CODE, 32'h0);
    check("code reg", q[12:8], prov[4:0]);
    wb(1'b1, REG_CTRL, 32'h3);
    prov = 0;
    codes();
    repeat (3) pm.pulse(1'b0, 10);
    pm.pulse(1'b1, 10);
    pm.hold(260);
    codes();
    pm.seq(6, 1'b0, 1'b1);
    pm.pulse(1'b1, 10);
    prov = 6;
    codes();
    pm.seq(32, 1'b0, 1'b0);
    pm.pulse(1'b1, 10);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status prov", q, (32'h1 << STAT_SUP_BIT) | (32'h1 << STAT_PLOCK_BIT)
      | (32'(LOCK_ADDR) << STAT_ADDR_LSB) | 32'(ST_KEY1));
    check("not locked", {31'h0, locked}, 32'h0);
    pm.supply(1'b0);
    prov = 0;
    codes();
    $display("provisional test done");
    for (int a = 3; a >= 1; a -= 2) begin
      cycle_power();
      pm.seq(a, 1'b1, 1'b1);
      fz = fz | (1 << (a - 1));
    end
    cycle_power();
    check("fuses", {27'h0, fuse}, 32'h5);
    codes();
    pm.seq(7, 1'b1, 1'b1);
    cycle_power();
    check("no blow", {27'h0, fuse}, 32'h5);
    $display("permanent test done");
    pm.seq(32, 1'b1, 1'b1);
    cycle_power();
    check("locked", {31'h0, locked}, 32'h1);
    pm.seq(2, 1'b1, 1'b1);
    cycle_power();
    pm.seq(2, 1'b0, 1'b1);
    pm.hold(260);
    check("lock fuses", {27'h0, fuse}, 32'h5);
    codes();
    wb(1'b0, REG_STATUS, 32'h0);
    check("status lock", q, (32'h1 << STAT_SUP_BIT) | (32'h1 << STAT_LOCK_BIT));
    wb(1'b0, REG_CODE, 32'h0);
    check("code fuses", q, (32'(fz) << CODE_FUSE_LSB) | 32'(fz));
    $display("lock test done");
    wrap_up();
  end
endmodule : test_spt_programmer
